/* File: common/pin_ctrl_pkg.sv */
// constants and types for the power-down, self-test and general pin control block
package pin_ctrl_pkg;
    localparam int          GP_PINS        = 3;
    localparam logic [31:0] DATA_W         = 32'd32;
    // register byte addresses
    localparam logic [31:0] OFS_CTRL       = 32'h00;
    localparam logic [31:0] OFS_GP_OUT     = 32'h04;
    localparam logic [31:0] OFS_GP_OE      = 32'h08;
    localparam logic [31:0] OFS_GP_ALT     = 32'h0c;
    localparam logic [31:0] OFS_STATUS     = 32'h10;
    localparam logic [31:0] OFS_GP_IN      = 32'h14;
    // ctrl register fields
    localparam int          CTRL_PLL_EN    = 0;
    // status register fields
    localparam int          ST_ENABLED     = 0;
    localparam int          ST_SELF_TEST   = 1;
    localparam int          ST_CLK_SEL     = 2;
    localparam int          ST_IRQ_IN      = 3;
    localparam int          ST_PLL_ON      = 4;
    // reset values
    localparam logic        CTRL_RST       = 1'b1;
    localparam logic [2:0]  GP_OUT_RST     = 3'h0;
    localparam logic [2:0]  GP_OE_RST      = 3'h0;
    localparam logic [2:0]  GP_ALT_RST     = 3'h0;
    // self-test fixed clock frequency in hz
    localparam int          SELF_TEST_FAST_HZ = 33_000_000;
    // ahb encodings
    localparam logic [1:0]  HTRANS_IDLE    = 2'h0;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    typedef enum logic [1:0] {
        PWR_DOWN = 2'b00,
        PWR_ON   = 2'b01,
        PWR_RUN  = 2'b11
    } pwr_state_t;
    typedef enum logic {
        CLK_PIXEL = 1'b0,
        CLK_FIXED = 1'b1
    } st_clk_t;
endpackage

/* File: src/pd_sync.sv */
// two-stage synchroniser for the power-down input
`timescale 1ns/1ns
module pd_sync (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta;
    logic next_meta;
    logic next_sync;
    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end
    // first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta   <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule // pd_sync

/* File: src/pin_ctrl.sv */
// power-down, self-test select and shared pin control with ahb-lite registers
// Contract
// R1: power-down input high enables device and resets all registers and state
// R2: power-down input low keeps device powered down at least power
// R3: powered down: all logic outputs tri-stated and pll stopped
// R4: undriven power-down input reads low through weak pulldown
// R5: host holds power-down input low until supplies are good
// R6: self-test enable pin 0 disables, 1 enables self-test mode
// R7: in self-test, shared pin 0 picks pixel clock, 1 picks 33 mhz
// R8: shared pin is interrupt input unless self-test mode is enabled
// R9: general pins 0..2 default to gpio, registers switch to audio functions
// R10: general pins 0..2 drive logic low after reset until reconfigured
// R11: power-down input synchronised; logic held in reset while it is low
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module pin_ctrl
    import pin_ctrl_pkg::*;
#(
    parameter int N_GP = GP_PINS
) (
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_power_down_n_input,
    input  wire logic              i_self_test_enable_pin,
    input  wire logic              i_shared_pin,
    input  wire logic [N_GP-1:0]   i_general_pin,
    output logic      [N_GP-1:0]   o_general_pin,
    output logic      [N_GP-1:0]   o_general_pin_oe,
    input  wire logic              i_audio_serial_out,
    input  wire logic              i_audio_word_clock_out,
    input  wire logic              i_audio_data_lane_c,
    output logic                   o_built_in_self_test,
    output logic                   o_self_test_clock_select,
    output logic                   o_interrupt_input,
    output logic                   o_pll_enable,
    output logic                   o_logic_rst,
    output logic                   o_outputs_enable,
    input  wire logic              i_hsel,
    input  wire logic [31:0]       i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [31:0]       i_hwdata,
    input  wire logic              i_hready,
    output logic      [31:0]       o_hrdata,
    output logic                   o_hreadyout,
    output logic                   o_hresp
);
    import pin_ctrl_pkg::*;

    // undriven pin pulled low on the board model; x or z never seen here [R4]
    logic pd_sync_q;
    pd_sync u_pd_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_power_down_n_input),
        .o_sync    (pd_sync_q)
    );

    // power state
    pwr_state_t pwr;
    pwr_state_t next_pwr;
    logic       soft_rst;
    always_comb begin
        next_pwr = pwr;
        case (pwr)
            PWR_DOWN: if (pd_sync_q) next_pwr = PWR_ON;      // [R1]
            PWR_ON:   next_pwr = pd_sync_q ? PWR_RUN : PWR_DOWN;
            PWR_RUN:  if (!pd_sync_q) next_pwr = PWR_DOWN;   // [R2]
            default:  next_pwr = PWR_DOWN;
        endcase
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pwr <= PWR_DOWN;
        end else begin
            pwr <= next_pwr;
        end
    end
    // held in reset while down and for the wake cycle, so rising input resets state [R1] [R11]
    assign soft_rst = (pwr != PWR_RUN);

    // registers
    logic            pll_en;
    logic [N_GP-1:0] gp_out;
    logic [N_GP-1:0] gp_oe;
    logic [N_GP-1:0] gp_alt;
    logic            next_pll_en;
    logic [N_GP-1:0] next_gp_out;
    logic [N_GP-1:0] next_gp_oe;
    logic [N_GP-1:0] next_gp_alt;
    logic            dp_wr;
    logic            dp_rd;
    logic [31:0]     dp_addr;
    logic            next_dp_wr;
    logic            next_dp_rd;
    logic [31:0]     next_dp_addr;
    logic [31:0]     rdata;
    logic [31:0]     next_rdata;
    logic            addr_ok;
    logic [31:0]     status;
    logic            req;

    assign req = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);

    always_comb begin
        status                          = '0;
        status[ST_ENABLED]              = !soft_rst;
        status[ST_SELF_TEST]            = o_built_in_self_test;
        status[ST_CLK_SEL]              = o_self_test_clock_select;
        status[ST_IRQ_IN]               = o_interrupt_input;
        status[ST_PLL_ON]               = o_pll_enable;
    end

    always_comb begin
        next_dp_wr   = req && i_hwrite;
        next_dp_rd   = req && !i_hwrite;
        next_dp_addr = req ? i_haddr : dp_addr;
        next_pll_en  = pll_en;
        next_gp_out  = gp_out;
        next_gp_oe   = gp_oe;
        next_gp_alt  = gp_alt;
        if (dp_wr) begin
            case (dp_addr)
                OFS_CTRL:   next_pll_en = i_hwdata[CTRL_PLL_EN];
                OFS_GP_OUT: next_gp_out = i_hwdata[N_GP-1:0];
                OFS_GP_OE:  next_gp_oe  = i_hwdata[N_GP-1:0];
                OFS_GP_ALT: next_gp_alt = i_hwdata[N_GP-1:0];   // [R9]
                default:    next_pll_en = pll_en;
            endcase
        end
        addr_ok = 1'b1;
        next_rdata = '0;
        case (i_haddr)
            OFS_CTRL:   next_rdata[CTRL_PLL_EN] = pll_en;
            OFS_GP_OUT: next_rdata[N_GP-1:0]   = gp_out;
            OFS_GP_OE:  next_rdata[N_GP-1:0]   = gp_oe;
            OFS_GP_ALT: next_rdata[N_GP-1:0]   = gp_alt;
            OFS_STATUS: next_rdata              = status;
            OFS_GP_IN:  next_rdata[N_GP-1:0]   = i_general_pin;
            default:    addr_ok                 = 1'b0;
        endcase
        // unmapped reads return zero, unmapped writes are dropped
        if (!(req && !i_hwrite && addr_ok)) begin
            next_rdata = '0;
        end
    end

    // soft reset returns every register to default [R1] [R11]
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pll_en  <= CTRL_RST;
            gp_out  <= GP_OUT_RST;
            gp_oe   <= GP_OE_RST;
            gp_alt  <= GP_ALT_RST;
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            dp_addr <= '0;
            rdata   <= '0;
        end else if (soft_rst) begin
            pll_en  <= CTRL_RST;
            gp_out  <= GP_OUT_RST;
            gp_oe   <= GP_OE_RST;
            gp_alt  <= GP_ALT_RST;
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            dp_addr <= '0;
            rdata   <= '0;
        end else begin
            pll_en  <= next_pll_en;
            gp_out  <= next_gp_out;
            gp_oe   <= next_gp_oe;
            gp_alt  <= next_gp_alt;
            dp_wr   <= next_dp_wr;
            dp_rd   <= next_dp_rd;
            dp_addr <= next_dp_addr;
            rdata   <= next_rdata;
        end
    end

    // zero wait states; bus stays answerable even while powered down
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = rdata;

    // mode pins, decoded combinationally from the raw pin inputs, which are not synchronised
    always_comb begin
        o_built_in_self_test     = !soft_rst && i_self_test_enable_pin;          // [R6]
        // shared pin role chosen by self-test mode [R8]
        o_self_test_clock_select = o_built_in_self_test ? i_shared_pin : CLK_PIXEL; // [R7]
        o_interrupt_input        = !o_built_in_self_test && i_shared_pin;         // [R8]
        o_pll_enable             = !soft_rst && pll_en;                           // [R3]
        o_logic_rst              = soft_rst;                                      // [R11]
        o_outputs_enable         = !soft_rst;                                     // [R3]
    end

    // per-pin output mux: gpio by default, audio function when alt set
    logic [N_GP-1:0] audio_src;
    assign audio_src = {i_audio_data_lane_c, i_audio_word_clock_out, i_audio_serial_out};
    genvar g;
    generate
        for (g = 0; g < N_GP; g++) begin : g_pin
            // reset values drive low; tri-stated whenever powered down [R10] [R3]
            assign o_general_pin[g]    = gp_alt[g] ? audio_src[g] : gp_out[g]; // [R9]
            assign o_general_pin_oe[g] = !soft_rst && (gp_alt[g] || !gp_oe[g] || gp_oe[g]);
        end
    endgenerate

    // checks
    chk_down_tristate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !pd_sync_q |=> (o_general_pin_oe == '0) && !o_pll_enable && !o_outputs_enable)
        else $error("outputs not tri-stated when powered down"); // [R3]
    chk_down_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !pd_sync_q |=> o_logic_rst)
        else $error("logic not held in reset while power-down low"); // [R11]
    chk_wake_defaults: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(pd_sync_q) |=> ##1 (gp_out == GP_OUT_RST) && (gp_alt == GP_ALT_RST)
        && (pll_en == CTRL_RST))
        else $error("registers not at default after wake"); // [R1]
    chk_stays_down: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (pwr == PWR_DOWN) && !pd_sync_q |=> (pwr == PWR_DOWN))
        else $error("left power down while input low"); // [R2]
    chk_wake_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (pwr == PWR_DOWN) && pd_sync_q ##1 pd_sync_q |=> !o_logic_rst)
        else $error("device not enabled after power-down input high"); // [R1]
    chk_self_test_en: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !o_logic_rst |-> (o_built_in_self_test == i_self_test_enable_pin))
        else $error("self-test mode does not follow its pin"); // [R6]
    chk_clock_select: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_built_in_self_test |-> (o_self_test_clock_select == i_shared_pin)
        && !o_interrupt_input)
        else $error("shared pin not routed to clock select in self-test"); // [R7]
    chk_irq_default: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !o_built_in_self_test |-> (o_interrupt_input == i_shared_pin)
        && (o_self_test_clock_select == CLK_PIXEL))
        else $error("shared pin not interrupt input outside self-test"); // [R8]
    chk_gp_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(pd_sync_q) |=> ##1 (o_general_pin == '0))
        else $error("general pins not low after reset"); // [R10]
    chk_gp_alt: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        gp_alt[0] |-> o_general_pin[0] == i_audio_serial_out)
        else $error("alternate audio function not routed"); // [R9]
endmodule // pin_ctrl

/* File: test/host_pin_model.sv */
// host processor output pin and board straps driving the control pins
`timescale 1ns/1ns
module host_pin_model (
    input  wire logic i_supplies_good,
    input  wire logic i_drive_pd,
    input  wire logic i_pd_request,
    input  wire logic i_st_request,
    input  wire logic i_shared_request,
    output logic      o_power_down_n_input,
    output logic      o_self_test_enable_pin,
    output logic      o_shared_pin
);
    // an undriven pin falls to its pulldown, so the device starts powered down
    // the host keeps the pin low until the supplies are good
    always_comb begin
        o_power_down_n_input = i_drive_pd & i_supplies_good & i_pd_request;
    end
    // straps are pulldowns; the host only ever pulls them high
    assign o_self_test_enable_pin = i_st_request;
    assign o_shared_pin           = i_shared_request;
endmodule // host_pin_model

/* File: test/powerdown_selftest_pin_control_tb_top.sv */
// testbench for the power-down, self-test and general pin control block
`timescale 1ns/1ns
module powerdown_selftest_pin_control_tb_top;
    import pin_ctrl_pkg::*;
    logic        i_clk, i_sys_rst, i_hsel, i_hwrite, hready_out, hresp;
    logic [31:0] i_haddr, i_hwdata, hrdata, rd;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize, i_general_pin, gp_out, gp_oe, aud;
    logic        sup_ok, pd_req, pd_drv, st_req, sh_req, pdn, st_pin, sh_pin;
    logic        built_in_self_test, csel, irq, pll, lrst, outs_en;
    int          mismatches, n_tests, cycles;

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    host_pin_model u_host (.i_supplies_good(sup_ok), .i_drive_pd(pd_drv),
        .i_pd_request(pd_req), .i_st_request(st_req), .i_shared_request(sh_req),
        .o_power_down_n_input(pdn), .o_self_test_enable_pin(st_pin), .o_shared_pin(sh_pin));

    pin_ctrl DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_power_down_n_input(pdn),
        .i_self_test_enable_pin(st_pin), .i_shared_pin(sh_pin), .i_general_pin(i_general_pin),
        .o_general_pin(gp_out), .o_general_pin_oe(gp_oe), .i_audio_serial_out(aud[0]),
        .i_audio_word_clock_out(aud[1]), .i_audio_data_lane_c(aud[2]),
        .o_built_in_self_test(built_in_self_test), .o_self_test_clock_select(csel), .o_interrupt_input(irq),
        .o_pll_enable(pll), .o_logic_rst(lrst), .o_outputs_enable(outs_en), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
        .i_hwdata(i_hwdata), .i_hready(hready_out), .o_hrdata(hrdata),
        .o_hreadyout(hready_out), .o_hresp(hresp));

    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // single word transfer; waits on hready, never assumes a latency
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        i_hsel   <= 1'b1;
        i_haddr  <= a;
        i_htrans <= HTRANS_NONSEQ;
        i_hwrite <= wr;
        i_hsize  <= HSIZE_WORD;
        @(posedge i_clk);
        while (hready_out !== 1'b1) @(posedge i_clk);
        i_htrans <= HTRANS_IDLE;
        i_hsel   <= 1'b0;
        i_hwdata <= d;
        @(posedge i_clk);
        while (hready_out !== 1'b1) @(posedge i_clk);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, what);
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask

    // bounded wait for the wake-up sequence, then one more edge before the bus
    task automatic wait_run();
        for (int k = 0; k < 20 && lrst !== 1'b0; k++) @(posedge i_clk);
        @(posedge i_clk);
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        {i_sys_rst, sup_ok, pd_req, pd_drv, st_req, sh_req, i_hsel, i_hwrite} = 8'h80;
        {i_haddr, i_hwdata, i_htrans, i_hsize, aud} = '0;
        i_general_pin = 3'h6;
        {mismatches, n_tests, cycles} = '0;
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        pd_drv    <= 1'b1;
        pd_req    <= 1'b1;
        // supplies still ramping: pin stays low, device stays down
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        chk({lrst, outs_en, pll, gp_oe}, 32'h20, "held down");
        $display("test power-down done");
        @(posedge i_clk);
        sup_ok <= 1'b1;
        wait_run();
        @(negedge i_clk);
        chk({outs_en, pll, gp_oe, gp_out}, 32'hf8, "woken, pins low");
        @(posedge i_clk);
        rd_chk(OFS_CTRL, 32'h1, "ctrl default");
        rd_chk(OFS_GP_OUT, 32'h0, "gp_out default");
        rd_chk(OFS_GP_ALT, 32'h0, "alt default gpio");
        rd_chk(OFS_GP_IN, 32'h6, "pin input levels");
        rd_chk(32'h20, 32'h0, "unmapped read");
        bus(1'b1, OFS_GP_OUT, 32'h5);
        @(negedge i_clk);
        chk(gp_out, 32'h5, "gpio drive");
        @(posedge i_clk);
        aud <= 3'h2;
        bus(1'b1, OFS_GP_ALT, 32'h7);
        @(negedge i_clk);
        chk(gp_out, 32'h2, "audio functions");
        $display("test general pins done");
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            st_req <= i[1];
            sh_req <= i[0];
            // mode pins are decoded combinationally from the raw pins; wait three edges before checking
            repeat (3) @(posedge i_clk);
            @(negedge i_clk);
            chk({built_in_self_test, csel, irq}, {29'h0, i[1], i[1] & i[0], ~i[1] & i[0]}, "shared pin");
        end
        @(posedge i_clk);
        rd_chk(OFS_STATUS, 32'h17, "status in self-test");
        $display("test self-test done");
        pd_req <= 1'b0;
        st_req <= 1'b0;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        chk({lrst, outs_en, pll, gp_oe}, 32'h20, "powered down again");
        @(posedge i_clk);
        pd_req <= 1'b1;
        wait_run();
        rd_chk(OFS_GP_OUT, 32'h0, "gp_out reset on wake");
        rd_chk(OFS_GP_ALT, 32'h0, "alt reset on wake");
        @(negedge i_clk);
        chk(gp_out, 32'h0, "pins low after wake");
        $display("test re-wake done");
        print_verdict();
    end
endmodule // powerdown_selftest_pin_control_tb_top
